// *** hw/interval_timer.sv ***
// Down-counter that stays busy for a loaded number of core cycles.
// Assumes start is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module interval_timer #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         clear,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    output logic              busy
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = load;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (clear) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);

endmodule : interval_timer

// *** hw/led_soc_power_mode_control.sv ***
// Power sequencer, mode control and serial host register access.
// Assumes the supply and regulator monitors deliver asynchronous levels and
// the bus pins are open drain with external pull-ups.
//
// Summary of operation
// - Power-on reset restores register defaults and keeps LED drive off.
// - Low supply or low regulator output asserts power-on reset again.
// - A low enable pin holds the device in reset.
// - Enable low after power-up keeps the device in shutdown.
// - Shutdown keeps everything idle; the host interface ignores bus traffic.
// - Enable going high moves shutdown to standby and opens the host port.
// - Standby keeps oscillator off and regulator in low-power operation.
// - Setting the active-request bit in standby enters active.
// - Active starts oscillator and full regulator before clocked functions.
// - Clearing the active-request bit returns to standby, LED drive off.
// - Writing 0x55 to register 0x01 resets circuits and registers.
// - The target answers at one of two addresses set by a pin.
// - Address select low gives 0x6A, high gives 0x6B.
// - The interrupt pin is pulled low to signal, released otherwise.
`timescale 1ns/1ps
module led_soc_power_mode_control #(
    parameter int QUIET_CYCLES = pmc_pkg::SOFT_RESET_WAIT_CYCLES,
    parameter int WAKE_CYCLES  = pmc_pkg::OSC_START_CYCLES
) (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          en_pin,
    input  wire logic          addr_sel_pin,
    input  wire logic          supply_low,
    input  wire logic          regulator_low,
    input  wire logic          scl_pin,
    input  wire logic          sda_pin,
    output logic               sda_drive_level,
    output logic               sda_oe,
    input  wire logic          irq_request,
    output logic               irq_out_low_level,
    output logic               irq_out_low_oe,
    output pmc_pkg::power_ctrl_t power_ctrl,
    output logic [7:0]         undervoltage_threshold
);
    localparam int QW = $clog2(QUIET_CYCLES + 1);
    localparam int WW = $clog2(WAKE_CYCLES + 1);

    // ****************************************
    // Pin synchronisers and reset sources
    // ****************************************
    logic [5:0] pins_s;
    logic en_s, addr_sel_s, supply_low_s, regulator_low_s, scl_s, sda_s;
    logic scl_q, sda_q;
    logic hard_rst, enable_rst, core_rst, soft_rst, soft_req;

    pin_sync #(
        .W         (6),
        .RESET_VAL (pmc_pkg::PIN_SYNC_RESET)
    ) u_pin_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in ({en_pin, addr_sel_pin, supply_low, regulator_low,
                    scl_pin, sda_pin}),
        .sync_out (pins_s)
    );

    assign {en_s, addr_sel_s, supply_low_s, regulator_low_s, scl_s, sda_s} =
        pins_s;

    assign hard_rst   = !nrst || supply_low_s || regulator_low_s;
    assign enable_rst = hard_rst || !en_s;
    assign core_rst   = enable_rst || soft_rst;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // ****************************************
    // Operating mode sequencer
    // ****************************************
    pmc_pkg::power_state_t pstate, next_pstate;
    logic gcr_active, next_gcr_active;
    logic [7:0] uv_threshold, next_uv_threshold;
    logic wake_busy, wake_start, quiet;

    assign wake_start = (pstate == pmc_pkg::P_STANDBY) && gcr_active;

    interval_timer #(
        .W (WW)
    ) u_wake_timer (
        .core_clk (core_clk),
        .clear    (core_rst),
        .start    (wake_start),
        .load     (WW'(WAKE_CYCLES)),
        .busy     (wake_busy)
    );

    always_comb begin
        next_pstate = pstate;
        case (pstate)
            pmc_pkg::P_SHUTDOWN: next_pstate = pmc_pkg::P_STANDBY;
            pmc_pkg::P_STANDBY: begin
                if (gcr_active) begin
                    next_pstate = pmc_pkg::P_WAKING;
                end
            end
            pmc_pkg::P_WAKING: begin
                if (!gcr_active) begin
                    next_pstate = pmc_pkg::P_STANDBY;
                end else if (!wake_busy) begin
                    next_pstate = pmc_pkg::P_ACTIVE;
                end
            end
            pmc_pkg::P_ACTIVE: begin
                if (!gcr_active) begin
                    next_pstate = pmc_pkg::P_STANDBY;
                end
            end
            default: next_pstate = pmc_pkg::P_SHUTDOWN;
        endcase
    end

    // Software reset leaves the enabled device in standby so that the
    // acknowledge of the reset command itself still completes.
    always_ff @(posedge core_clk) begin
        if (enable_rst) begin
            pstate <= pmc_pkg::P_SHUTDOWN;
        end else if (soft_rst) begin
            pstate <= pmc_pkg::P_STANDBY;
        end else begin
            pstate <= next_pstate;
        end
    end

    always_comb begin
        power_ctrl.osc_run        = (pstate == pmc_pkg::P_WAKING) ||
                                    (pstate == pmc_pkg::P_ACTIVE);
        power_ctrl.regulator_full = power_ctrl.osc_run;
        power_ctrl.core_run       = (pstate == pmc_pkg::P_ACTIVE);
        power_ctrl.led_drive_on   = (pstate == pmc_pkg::P_ACTIVE);
        power_ctrl.host_if_open   = (pstate != pmc_pkg::P_SHUTDOWN);
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    pmc_pkg::reg_write_t wr;

    assign soft_req = wr.stb && (wr.addr == pmc_pkg::REG_SOFT_RESET) &&
                      (wr.data == pmc_pkg::SOFT_RESET_CODE);

    always_comb begin
        next_gcr_active   = gcr_active;
        next_uv_threshold = uv_threshold;
        if (wr.stb && (wr.addr == pmc_pkg::REG_GLOBAL_CONTROL)) begin
            next_gcr_active = wr.data[pmc_pkg::ACTIVE_REQUEST_POS];
        end else if (wr.stb && (wr.addr == pmc_pkg::REG_UV_THRESHOLD)) begin
            next_uv_threshold = wr.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (core_rst) begin
            gcr_active   <= 1'b0;
            uv_threshold <= pmc_pkg::UV_THRESHOLD_RESET;
        end else begin
            gcr_active   <= next_gcr_active;
            uv_threshold <= next_uv_threshold;
        end
    end

    always_ff @(posedge core_clk) begin
        if (enable_rst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= soft_req;
        end
    end

    assign undervoltage_threshold = uv_threshold;

    // Silence window after a software reset; the host is expected to wait.
    interval_timer #(
        .W (QW)
    ) u_quiet_timer (
        .core_clk (core_clk),
        .clear    (enable_rst),
        .start    (soft_req),
        .load     (QW'(QUIET_CYCLES)),
        .busy     (quiet)
    );

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == pmc_pkg::REG_GLOBAL_CONTROL) begin
            d[pmc_pkg::ACTIVE_REQUEST_POS] = gcr_active;
        end else if (a == pmc_pkg::REG_UV_THRESHOLD) begin
            d = uv_threshold;
        end else if (a == pmc_pkg::REG_POWER_STATUS) begin
            d = {4'h0, pstate};
        end
        return d;
    endfunction : read_reg

    // ****************************************
    // Serial host target
    // ****************************************
    pmc_pkg::host_state_t ist, next_ist;
    pmc_pkg::byte_phase_t phase, next_phase;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg, reg_ptr, next_reg_ptr, rd;
    logic       rw, next_rw, sda_drv, next_sda_drv;
    logic       scl_rise, scl_fall, bus_start, bus_stop, byte_done;
    logic [6:0] own_addr;

    assign own_addr  = addr_sel_s ? pmc_pkg::TARGET_ADDR_HIGH
                                  : pmc_pkg::TARGET_ADDR_LOW;
    assign scl_rise  = scl_s && !scl_q;
    assign scl_fall  = !scl_s && scl_q;
    assign bus_start = scl_s && scl_q && sda_q && !sda_s;
    assign bus_stop  = scl_s && scl_q && !sda_q && sda_s;
    assign byte_done = scl_fall && (bit_cnt == pmc_pkg::BYTE_BITS);
    always_comb rd = read_reg(reg_ptr);

    always_comb begin
        next_ist     = ist;
        next_phase   = phase;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_reg_ptr = reg_ptr;
        next_rw      = rw;
        next_sda_drv = sda_drv;
        wr           = '0;
        if (bus_stop) begin
            next_ist     = pmc_pkg::I_IDLE;
            next_sda_drv = 1'b0;
        end else if (bus_start) begin
            next_ist     = pmc_pkg::I_RECV;
            next_phase   = pmc_pkg::PH_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_drv = 1'b0;
        end else begin
            case (ist)
                pmc_pkg::I_RECV: begin
                    if (scl_rise) begin
                        next_shreg   = {shreg[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        next_ist     = pmc_pkg::I_ACK;
                        next_sda_drv = 1'b1;
                        if (phase == pmc_pkg::PH_ADDR) begin
                            next_rw = shreg[0];
                            if ((shreg[7:1] != own_addr) || quiet) begin
                                next_ist     = pmc_pkg::I_IDLE;
                                next_sda_drv = 1'b0;
                            end
                        end else if (phase == pmc_pkg::PH_REG) begin
                            next_reg_ptr = shreg;
                        end else begin
                            wr.stb  = 1'b1;
                            wr.addr = reg_ptr;
                            wr.data = shreg;
                        end
                    end
                end
                pmc_pkg::I_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        next_sda_drv = 1'b0;
                        next_ist     = pmc_pkg::I_RECV;
                        if (phase == pmc_pkg::PH_ADDR && rw) begin
                            next_ist     = pmc_pkg::I_SEND;
                            next_shreg   = rd;
                            next_sda_drv = !rd[7];
                            next_bit_cnt = 4'h1;
                        end else if (phase == pmc_pkg::PH_ADDR) begin
                            next_phase = pmc_pkg::PH_REG;
                        end else if (phase == pmc_pkg::PH_REG) begin
                            next_phase = pmc_pkg::PH_DATA;
                        end else begin
                            next_reg_ptr = reg_ptr + 8'h01;
                        end
                    end
                end
                pmc_pkg::I_SEND: begin
                    if (byte_done) begin
                        next_ist     = pmc_pkg::I_MACK;
                        next_sda_drv = 1'b0;
                    end else if (scl_fall) begin
                        next_sda_drv = !shreg[6];
                        next_shreg   = {shreg[6:0], 1'b0};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                end
                pmc_pkg::I_MACK: begin
                    if (scl_rise && sda_s) begin
                        next_ist = pmc_pkg::I_IDLE;
                    end else if (scl_rise) begin
                        next_ist     = pmc_pkg::I_LOAD;
                        next_reg_ptr = reg_ptr + 8'h01;
                    end
                end
                pmc_pkg::I_LOAD: begin
                    if (scl_fall) begin
                        next_ist     = pmc_pkg::I_SEND;
                        next_shreg   = rd;
                        next_sda_drv = !rd[7];
                        next_bit_cnt = 4'h1;
                    end
                end
                default: next_ist = pmc_pkg::I_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (enable_rst || !power_ctrl.host_if_open) begin
            ist     <= pmc_pkg::I_IDLE;
            phase   <= pmc_pkg::PH_ADDR;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            reg_ptr <= 8'h00;
            rw      <= 1'b0;
            sda_drv <= 1'b0;
        end else begin
            ist     <= next_ist;
            phase   <= next_phase;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            reg_ptr <= next_reg_ptr;
            rw      <= next_rw;
            sda_drv <= next_sda_drv;
        end
    end

    assign sda_drive_level = 1'b0;
    assign sda_oe          = sda_drv;

    // ****************************************
    // Interrupt pin
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (enable_rst) begin
            irq_out_low_oe <= 1'b0;
        end else begin
            irq_out_low_oe <= irq_request;
        end
    end

    assign irq_out_low_level = 1'b0;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    chk_reset_defaults: assert property (
        hard_rst |=> pstate == pmc_pkg::P_SHUTDOWN && !gcr_active &&
            uv_threshold == pmc_pkg::UV_THRESHOLD_RESET &&
            !power_ctrl.led_drive_on)
        else $error("Reset did not restore defaults.");
    chk_monitor_reset: assert property (
        (supply_low_s || regulator_low_s) |=> pstate == pmc_pkg::P_SHUTDOWN)
        else $error("Monitor low did not reset the device.");
    chk_enable_low: assert property (
        !en_s |=> pstate == pmc_pkg::P_SHUTDOWN && !sda_oe)
        else $error("Enable low did not hold reset.");
    chk_shutdown_idle: assert property (
        pstate == pmc_pkg::P_SHUTDOWN |-> !sda_oe && !power_ctrl.osc_run &&
            !power_ctrl.host_if_open && ist == pmc_pkg::I_IDLE)
        else $error("Activity seen in shutdown.");
    chk_enable_rise: assert property (
        (pstate == pmc_pkg::P_SHUTDOWN && !enable_rst) |=>
            pstate == pmc_pkg::P_STANDBY && power_ctrl.host_if_open)
        else $error("Enable high did not reach standby.");
    chk_standby_idle: assert property (
        pstate == pmc_pkg::P_STANDBY |-> !power_ctrl.osc_run &&
            !power_ctrl.regulator_full && !power_ctrl.core_run)
        else $error("Clocked function running in standby.");
    chk_wake_entry: assert property (
        (pstate == pmc_pkg::P_STANDBY && gcr_active && !core_rst) |=>
            pstate == pmc_pkg::P_WAKING ##1 power_ctrl.osc_run[*2])
        else $error("Active request did not wake the device.");
    chk_osc_first: assert property (
        $rose(power_ctrl.core_run) |-> $past(power_ctrl.osc_run, 2) &&
            $past(power_ctrl.regulator_full))
        else $error("Core ran before oscillator and regulator.");
    chk_sleep_leds: assert property (
        (pstate == pmc_pkg::P_ACTIVE && !gcr_active && !core_rst) |=>
            pstate == pmc_pkg::P_STANDBY && !power_ctrl.led_drive_on)
        else $error("Clearing active request left LEDs on.");
    chk_soft_reset: assert property (
        (soft_req && !enable_rst) |=> soft_rst ##1 (!gcr_active &&
            uv_threshold == pmc_pkg::UV_THRESHOLD_RESET && quiet))
        else $error("Software reset did not clear registers.");
    chk_other_code: assert property (
        (wr.stb && wr.addr == pmc_pkg::REG_SOFT_RESET &&
            wr.data != pmc_pkg::SOFT_RESET_CODE) |=> !soft_rst)
        else $error("Wrong code caused a software reset.");
    chk_addr_ack: assert property (
        (ist == pmc_pkg::I_RECV && phase == pmc_pkg::PH_ADDR && byte_done &&
            !bus_start && !bus_stop && !quiet && shreg[7:1] == own_addr)
            |=> sda_oe && ist == pmc_pkg::I_ACK)
        else $error("Own address not acknowledged.");
    chk_quiet_nack: assert property (
        (ist == pmc_pkg::I_RECV && phase == pmc_pkg::PH_ADDR && byte_done &&
            quiet) |=> !sda_oe && ist == pmc_pkg::I_IDLE)
        else $error("Address acknowledged during reset wait.");
    chk_irq_drive: assert property (
        (irq_request && !enable_rst) |=> irq_out_low_oe &&
            irq_out_low_level == 1'b0)
        else $error("Interrupt pin not pulled low.");

endmodule : led_soc_power_mode_control

// *** hw/pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the levels change slowly against the core clock.
`timescale 1ns/1ps
module pin_sync #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : pin_sync

// *** hw/pmc_pkg.sv ***
// Shared constants and types for the power and operating-mode controller.
// Assumes a single 50 MHz core clock and a two-wire serial host interface.
package pmc_pkg;

    // ****************************************
    // Host interface addresses and registers
    // ****************************************
    localparam logic [6:0] TARGET_ADDR_LOW    = 7'h6A;
    localparam logic [6:0] TARGET_ADDR_HIGH   = 7'h6B;
    localparam logic [7:0] REG_SOFT_RESET     = 8'h01;
    localparam logic [7:0] REG_GLOBAL_CONTROL = 8'h02;
    localparam logic [7:0] REG_UV_THRESHOLD   = 8'h10;
    localparam logic [7:0] REG_POWER_STATUS   = 8'hF0;
    localparam logic [7:0] SOFT_RESET_CODE    = 8'h55;
    localparam logic [7:0] UV_THRESHOLD_RESET = 8'h03;
    localparam int         ACTIVE_REQUEST_POS = 0;
    localparam logic [3:0] BYTE_BITS          = 4'h8;
    localparam logic [5:0] PIN_SYNC_RESET     = 6'h03;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CORE_CLK_HZ             = 50_000_000;
    localparam int SOFT_RESET_WAIT_MS      = 2;
    localparam int SOFT_RESET_WAIT_CYCLES  =
        (SOFT_RESET_WAIT_MS * CORE_CLK_HZ + 999) / 1000;
    localparam int OSC_START_CYCLES        = 16;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        P_SHUTDOWN = 4'b0001,
        P_STANDBY  = 4'b0010,
        P_WAKING   = 4'b0100,
        P_ACTIVE   = 4'b1000
    } power_state_t;

    typedef enum logic [5:0] {
        I_IDLE = 6'b000001,
        I_RECV = 6'b000010,
        I_ACK  = 6'b000100,
        I_SEND = 6'b001000,
        I_MACK = 6'b010000,
        I_LOAD = 6'b100000
    } host_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_REG  = 2'h1,
        PH_DATA = 2'h2
    } byte_phase_t;

    typedef struct packed {
        logic osc_run;
        logic regulator_full;
        logic core_run;
        logic led_drive_on;
        logic host_if_open;
    } power_ctrl_t;

    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

endpackage : pmc_pkg

// *** tb/i2c_host_model.sv ***
// Host controller model that drives the two-wire serial bus.
// Assumes an external pull-up; the target pulls SDA low via its enable.
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic core_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic half();
        repeat (6) @(posedge core_clk);
    endtask : half
    task automatic start();
        sda <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask : start
    task automatic stop();
        sda <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda <= 1'b1;
        half();
    endtask : stop
    // Sends one byte MSB first, then releases SDA and samples the answer.
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda <= (i == 0) ? 1'b1 : b[i-1];
            half();
            scl <= 1'b1;
            half();
            ack = ~sda_wire;
            scl <= 1'b0;
            half();
        end
    endtask : send
    // Reads one byte MSB first, then drives the given acknowledge bit.
    task automatic recv(input logic nack, output logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            sda <= (i < 0) ? nack : 1'b1;
            half();
            scl <= 1'b1;
            half();
            if (i >= 0) begin
                b[i] = sda_wire;
            end
            scl <= 1'b0;
            half();
        end
    endtask : recv
endmodule : i2c_host_model

// *** tb/led_soc_power_mode_control_tb.sv ***
// Self-checking bench for the power and mode controller.
// Assumes the host model in i2c_host_model and an SDA pull-up.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); \
    end end
module led_soc_power_mode_control_tb;
    localparam int QUIET = 400;
    localparam int WAKE  = 4;
    logic                 core_clk, nrst, en_pin, addr_sel_pin, irq_request;
    logic                 supply_low, regulator_low, scl, sda, sda_oe;
    logic                 irq_oe, ack, dmy, sda_lvl, irq_lvl;
    logic [7:0]           uv, val, got;
    pmc_pkg::power_ctrl_t power_ctrl;
    int                   n_errors = 0;
    int                   n_compared = 0;
    wire logic            sda_wire = sda & (sda_oe ? sda_lvl : 1'b1);
    wire logic            irq_wire = irq_oe ? irq_lvl : 1'b1;
    led_soc_power_mode_control #(
        .QUIET_CYCLES(QUIET), .WAKE_CYCLES(WAKE)) dut (
        .core_clk(core_clk), .nrst(nrst), .en_pin(en_pin),
        .addr_sel_pin(addr_sel_pin), .supply_low(supply_low),
        .regulator_low(regulator_low), .scl_pin(scl), .sda_pin(sda_wire),
        .sda_drive_level(sda_lvl), .sda_oe(sda_oe),
        .irq_request(irq_request),
        .irq_out_low_level(irq_lvl), .irq_out_low_oe(irq_oe),
        .power_ctrl(power_ctrl), .undervoltage_threshold(uv));
    i2c_host_model host (.core_clk(core_clk), .sda_wire(sda_wire),
        .scl(scl), .sda(sda));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic [6:0] tgt(input logic sel);
        return sel ? 7'h6B : 7'h6A;
    endfunction : tgt
    function automatic pmc_pkg::power_ctrl_t mode(input logic on, act);
        return {act, act, act, act, on};
    endfunction : mode
    task automatic wr(input logic [6:0] a, input logic [7:0] r, d);
        host.start();
        host.send({a, 1'b0}, ack);
        if (ack) begin
            host.send(r, dmy);
            host.send(d, dmy);
        end
        host.stop();
    endtask : wr
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] r,
                          output logic [7:0] d);
        host.start();
        host.send({a, 1'b0}, ack);
        host.send(r, dmy);
        host.stop();
        host.start();
        host.send({a, 1'b1}, ack);
        host.recv(1'b1, d);
        host.stop();
    endtask : rd_reg
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(32'h0CBF));
        {nrst, en_pin, supply_low, regulator_low, irq_request} = 5'h00;
        addr_sel_pin = 1'($urandom);
        val = 8'($urandom) | 8'h80;
        repeat (8) @(posedge core_clk);
        `CHK("mode", mode(0, 0), power_ctrl)
        `CHK("uv", 8'h03, uv)
        nrst <= 1'b1;
        repeat (8) @(posedge core_clk);
        wr(tgt(addr_sel_pin), pmc_pkg::REG_UV_THRESHOLD, val);
        `CHK("ack", 1'b0, ack)
        `CHK("mode", mode(0, 0), power_ctrl)
        en_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        `CHK("mode", mode(1, 0), power_ctrl)
        wr(tgt(~addr_sel_pin), pmc_pkg::REG_UV_THRESHOLD, val);
        `CHK("ack", 1'b0, ack)
        wr(tgt(addr_sel_pin), pmc_pkg::REG_GLOBAL_CONTROL, 8'h01);
        `CHK("mode", mode(1, 1), power_ctrl)
        rd_reg(tgt(addr_sel_pin), pmc_pkg::REG_POWER_STATUS, got);
        `CHK("status", 8'h08, got)
        wr(tgt(addr_sel_pin), pmc_pkg::REG_GLOBAL_CONTROL, 8'h00);
        `CHK("mode", mode(1, 0), power_ctrl)
        wr(tgt(addr_sel_pin), pmc_pkg::REG_UV_THRESHOLD, val);
        rd_reg(tgt(addr_sel_pin), pmc_pkg::REG_UV_THRESHOLD, got);
        `CHK("uv read", val, got)
        wr(tgt(addr_sel_pin), pmc_pkg::REG_SOFT_RESET, 8'h54);
        `CHK("uv", val, uv)
        wr(tgt(addr_sel_pin), pmc_pkg::REG_SOFT_RESET, 8'h55);
        `CHK("uv", 8'h03, uv)
        wr(tgt(addr_sel_pin), pmc_pkg::REG_UV_THRESHOLD, val);
        `CHK("ack", 1'b0, ack)
        repeat (QUIET) @(posedge core_clk);
        for (int i = 0; i < 2; i++) begin
            wr(tgt(addr_sel_pin), pmc_pkg::REG_UV_THRESHOLD, val);
            `CHK("uv", val, uv)
            {supply_low, regulator_low} <= i ? 2'b01 : 2'b10;
            repeat (4) @(posedge core_clk);
            {supply_low, regulator_low} <= 2'b00;
            repeat (8) @(posedge core_clk);
            `CHK("uv", 8'h03, uv)
        end
        irq_request <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK("irq", 1'b1, irq_oe)
        `CHK("irq pin", 1'b0, irq_wire)
        irq_request <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK("irq", 1'b0, irq_oe)
        en_pin <= 1'b0;
        irq_request <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("mode", mode(0, 0), power_ctrl)
        `CHK("irq", 1'b0, irq_oe)
        final_report();
    end
endmodule : led_soc_power_mode_control_tb
